// >>> bram_pkg.sv
// Purpose: shared constants and types of the configurable block ram
// Assumes: one clock, synchronous active-high reset
// Notes: storage is kept as rows of 36 bits; every legal width divides 36
package bram_pkg;
    localparam int ROW_W = 36;
    localparam int ROWS = 512;
    localparam int ROW_AW = 9;
    localparam int ADDR_W = 14;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int PORTS = 2;
    localparam int TOTAL_BITS = 18432;
    localparam int DATA_ONLY_BITS = 16384;
    localparam int WIDEST_TDP = 18;
    localparam int BYTE_EN_MIN_W = 18;
    localparam int PARITY_MIN_W = 9;
    localparam logic [ROW_AW-1:0] PTR_RESET = 9'h000;
    localparam logic [ROW_AW-1:0] LAST_ROW = 9'h1ff;
    localparam logic [ROW_W-1:0] INIT_WORD_DEFAULT = 36'h000000000;

    typedef enum logic [2:0] {
        MODE_SINGLE = 3'b001,
        MODE_TRUE_DP = 3'b010,
        MODE_PSEUDO_DP = 3'b100
    } mode_type;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_LOAD = 3'b010,
        ST_SAVE = 3'b100
    } state_type;

    function automatic logic width_legal(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 9) || (w == 18) || (w == 36);
    endfunction

    // widths without a parity lane only reach the 16 Kbit data part
    function automatic int depth_of(input int w);
        return ((w % LANE_W) == 0) ? (TOTAL_BITS / w) : (DATA_ONLY_BITS / w);
    endfunction
endpackage

// >>> ram_port_path.sv
// Purpose: address mapping, write merge, read pick and read registers of one port
// Assumes: WIDTH is one of 1, 2, 4, 9, 18, 36
// Notes: the row that the port addresses is read back through row_data_in
module ram_port_path #(
    parameter int WIDTH = 18,
    parameter bit OUT_REG = 1'b0,
    parameter bit PARITY_GEN = 1'b0
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic port_rst_in,
    input wire logic enable_in,
    input wire logic write_in,
    input wire logic [13:0] addr_in,
    input wire logic [35:0] wdata_in,
    input wire logic [3:0] byte_en_in,
    input wire logic [35:0] row_data_in,
    output logic [8:0] row_out,
    output logic [35:0] wmask_out,
    output logic [35:0] wbits_out,
    output logic [35:0] rdata_out,
    output logic parity_err_out
);
    localparam int PER_ROW = bram_pkg::ROW_W / WIDTH;
    localparam int NLANES = WIDTH / bram_pkg::LANE_W;
    localparam logic [35:0] FIELD = 36'((37'h1 << WIDTH) - 37'h1);

    wire logic [5:0] offset = 6'((addr_in % 14'(PER_ROW)) * 14'(WIDTH));
    wire logic [35:0] be_mask;
    wire logic [35:0] wfix;
    wire logic [35:0] picked = (row_data_in >> offset) & FIELD;
    wire logic [3:0] lane_bad;
    logic [35:0] rd_q_reg;
    logic perr_q_reg;
    logic perr_out_reg;

    // word n of this port starts at bit n*WIDTH of the array
    assign row_out = 9'(addr_in / 14'(PER_ROW));

    genvar k;
    generate
        for (k = 0; k < bram_pkg::LANES; k++) begin : g_lane
            assign be_mask[k*9 +: 9] = (WIDTH >= bram_pkg::BYTE_EN_MIN_W) ? {9{byte_en_in[k]}} : 9'h1ff;
            if (PARITY_GEN && (k < NLANES)) begin : g_par
                assign wfix[k*9 +: 9] = {^wdata_in[k*9 +: 8], wdata_in[k*9 +: 8]};
                assign lane_bad[k] = ^picked[k*9 +: 9];
            end else begin : g_raw
                assign wfix[k*9 +: 9] = wdata_in[k*9 +: 9];
                assign lane_bad[k] = 1'b0;
            end
        end
    endgenerate

    assign wmask_out = (FIELD & be_mask) << offset;
    assign wbits_out = (wfix & FIELD) << offset;

    // first read stage: the addressed word, not the address, is registered on the clock edge of a read
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || port_rst_in) begin
            rd_q_reg <= 36'h000000000;
            perr_q_reg <= 1'b0;
        end else if (enable_in && !write_in) begin
            rd_q_reg <= picked;
            perr_q_reg <= |lane_bad;
        end
    end

    generate
        if (OUT_REG) begin : g_out_reg
            logic [35:0] rd_out_reg;
            always_ff @(posedge ref_clk_in) begin
                if (rst_in || port_rst_in) begin
                    rd_out_reg <= 36'h000000000;
                    perr_out_reg <= 1'b0;
                end else if (enable_in) begin
                    rd_out_reg <= rd_q_reg;
                    perr_out_reg <= perr_q_reg;
                end
            end
            assign rdata_out = rd_out_reg;
            assign parity_err_out = perr_out_reg;

            a_out_stage: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                (enable_in && !port_rst_in) |=> (rdata_out == $past(rd_q_reg)))
                else $error("output register did not take the first read stage");
        end else begin : g_no_out_reg
            assign rdata_out = rd_q_reg;
            assign parity_err_out = perr_q_reg;
            always_comb perr_out_reg = 1'b0;
        end
    endgenerate

    sequence rd_issue;
        enable_in && !write_in && !port_rst_in;
    endsequence

    a_read_stage: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        rd_issue |=> (rd_q_reg == $past(picked)))
        else $error("first read stage did not catch the addressed word");

    a_idle_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (!enable_in && !port_rst_in) |=> $stable(rdata_out))
        else $error("read data moved without a clock enable");

    a_byte_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (WIDTH >= bram_pkg::BYTE_EN_MIN_W && !byte_en_in[0]) |-> ((wmask_out >> offset) & 36'h1ff) == 36'h0)
        else $error("disabled byte lane still in the write mask");

    a_parity_even: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (PARITY_GEN && WIDTH >= bram_pkg::PARITY_MIN_W && write_in) |-> !(^wfix[8:0]))
        else $error("stored parity bit does not match its byte");
endmodule

// >>> configurable_block_ram.sv
// Purpose: 18 Kbit embedded block ram with single, true dual and pseudo dual port modes
// Assumes: both ports and the image logic run on ref_clk_in; shape is fixed by parameters
// Notes: port b is unused in single mode; in pseudo dual mode port a writes and port b reads
module configurable_block_ram #(
    parameter bram_pkg::mode_type MODE = bram_pkg::MODE_TRUE_DP,
    parameter int A_WIDTH = 18,
    parameter int B_WIDTH = 18,
    parameter bit A_OUT_REG = 1'b0,
    parameter bit B_OUT_REG = 1'b0,
    parameter bit PARITY_GEN = 1'b0,
    parameter logic [35:0] INIT_WORD = bram_pkg::INIT_WORD_DEFAULT
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic a_clk_en_in,
    input wire logic a_rst_in,
    input wire logic a_write_en_in,
    input wire logic [13:0] a_addr_in,
    input wire logic [35:0] a_wdata_in,
    input wire logic [3:0] a_byte_en_in,
    output logic [35:0] a_rdata_out,
    output logic a_parity_err_out,
    input wire logic b_clk_en_in,
    input wire logic b_rst_in,
    input wire logic b_write_en_in,
    input wire logic [13:0] b_addr_in,
    input wire logic [35:0] b_wdata_in,
    input wire logic [3:0] b_byte_en_in,
    output logic [35:0] b_rdata_out,
    output logic b_parity_err_out,
    input wire logic load_image_in,
    input wire logic save_image_in,
    output logic busy_out,
    output logic config_err_out
);
    localparam int WIDTHS [2] = '{A_WIDTH, B_WIDTH};
    localparam bit OUT_REGS [2] = '{A_OUT_REG, B_OUT_REG};

    // shape check: 36 bits is not offered with two read/write ports
    localparam bit SHAPE_OK = bram_pkg::width_legal(A_WIDTH) && bram_pkg::width_legal(B_WIDTH)
        && !(MODE == bram_pkg::MODE_TRUE_DP
             && (A_WIDTH > bram_pkg::WIDEST_TDP || B_WIDTH > bram_pkg::WIDEST_TDP));

    // port roles per mode
    localparam bit CAN_READ [2] = '{MODE != bram_pkg::MODE_PSEUDO_DP, MODE != bram_pkg::MODE_SINGLE};
    localparam bit CAN_WRITE [2] = '{1'b1, MODE == bram_pkg::MODE_TRUE_DP};

    logic [35:0] mem_reg [bram_pkg::ROWS];
    logic [35:0] shadow_reg [bram_pkg::ROWS];
    logic shadow_valid_reg;
    bram_pkg::state_type state_reg;
    bram_pkg::state_type state_next;
    logic [8:0] ptr_reg;
    logic [8:0] ptr_next;

    wire logic running = (state_reg == bram_pkg::ST_RUN) && SHAPE_OK;
    wire logic last_row = (ptr_reg == bram_pkg::LAST_ROW);
    wire logic [1:0] ce = {b_clk_en_in, a_clk_en_in};
    wire logic [1:0] wr_req = {b_write_en_in, a_write_en_in};
    wire logic [1:0] prst = {b_rst_in, a_rst_in};
    wire logic [13:0] addr [2];
    wire logic [35:0] wdata [2];
    wire logic [3:0] be [2];
    wire logic [1:0] en;
    wire logic [1:0] we;
    wire logic [1:0] in_range;
    wire logic [8:0] row [2];
    wire logic [35:0] mask [2];
    wire logic [35:0] bits [2];
    wire logic [35:0] rdata [2];
    wire logic [1:0] perr;
    wire logic [35:0] row_after_a;
    wire logic [35:0] base_b;
    wire logic [35:0] row_after_b;

    assign addr[0] = a_addr_in;
    assign addr[1] = b_addr_in;
    assign wdata[0] = a_wdata_in;
    assign wdata[1] = b_wdata_in;
    assign be[0] = a_byte_en_in;
    assign be[1] = b_byte_en_in;

    genvar p;
    generate
        for (p = 0; p < bram_pkg::PORTS; p++) begin : g_port
            // addresses past the depth of the shape are ignored
            assign in_range[p] = 32'(addr[p]) < bram_pkg::depth_of(WIDTHS[p]);
            assign en[p] = ce[p] && running && in_range[p]
                && (wr_req[p] ? CAN_WRITE[p] : CAN_READ[p]);
            assign we[p] = en[p] && wr_req[p];

            ram_port_path #(
                .WIDTH(WIDTHS[p]),
                .OUT_REG(OUT_REGS[p]),
                .PARITY_GEN(PARITY_GEN)
            ) u_path (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .port_rst_in(prst[p]),
                .enable_in(en[p]),
                .write_in(wr_req[p]),
                .addr_in(addr[p]),
                .wdata_in(wdata[p]),
                .byte_en_in(be[p]),
                .row_data_in(mem_reg[row[p]]),
                .row_out(row[p]),
                .wmask_out(mask[p]),
                .wbits_out(bits[p]),
                .rdata_out(rdata[p]),
                .parity_err_out(perr[p])
            );
        end
    endgenerate

    assign a_rdata_out = rdata[0];
    assign b_rdata_out = rdata[1];
    assign a_parity_err_out = perr[0];
    assign b_parity_err_out = perr[1];
    assign busy_out = (state_reg != bram_pkg::ST_RUN);
    assign config_err_out = !SHAPE_OK;

    // merge each port's field into its row; when both hit one row, b builds on a
    assign row_after_a = (mem_reg[row[0]] & ~mask[0]) | (bits[0] & mask[0]);
    assign base_b = (we[0] && row[0] == row[1]) ? row_after_a : mem_reg[row[1]];
    assign row_after_b = (base_b & ~mask[1]) | (bits[1] & mask[1]);

    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        unique case (state_reg)
            bram_pkg::ST_RUN: begin
                ptr_next = bram_pkg::PTR_RESET;
                if (load_image_in) begin
                    state_next = bram_pkg::ST_LOAD;
                end else if (save_image_in) begin
                    state_next = bram_pkg::ST_SAVE;
                end
            end
            bram_pkg::ST_LOAD, bram_pkg::ST_SAVE: begin
                ptr_next = ptr_reg + 9'h001;
                if (last_row) begin
                    state_next = bram_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = bram_pkg::ST_LOAD;
                ptr_next = bram_pkg::PTR_RESET;
            end
        endcase
    end

    // reset stands for power-up: the image is copied in before ports run
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= bram_pkg::ST_LOAD;
            ptr_reg <= bram_pkg::PTR_RESET;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (state_reg == bram_pkg::ST_LOAD && !rst_in) begin
            mem_reg[ptr_reg] <= shadow_valid_reg ? shadow_reg[ptr_reg] : INIT_WORD;
        end else begin
            if (we[0]) begin
                mem_reg[row[0]] <= row_after_a;
            end
            if (we[1]) begin
                mem_reg[row[1]] <= row_after_b;
            end
        end
    end

    // shadow store keeps the saved image across reloads, but not across reset
    always_ff @(posedge ref_clk_in) begin
        if (state_reg == bram_pkg::ST_SAVE && !rst_in) begin
            shadow_reg[ptr_reg] <= mem_reg[ptr_reg];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shadow_valid_reg <= 1'b0;
        end else if (state_reg == bram_pkg::ST_SAVE && last_row) begin
            shadow_valid_reg <= 1'b1;
        end
    end

    sequence image_start;
        state_reg == bram_pkg::ST_RUN && (load_image_in || save_image_in);
    endsequence

    sequence image_walk;
        busy_out && ptr_reg == bram_pkg::PTR_RESET ##1 busy_out && ptr_reg == 9'h001;
    endsequence

    a_reset_load: assert property (@(posedge ref_clk_in)
        rst_in |=> (state_reg == bram_pkg::ST_LOAD && ptr_reg == bram_pkg::PTR_RESET))
        else $error("reset did not start an image load");

    a_image_steps: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        image_start |=> image_walk)
        else $error("image copy did not walk the rows from zero");

    a_image_end: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (busy_out && last_row) |=> (!busy_out ##0 ptr_reg == bram_pkg::PTR_RESET))
        else $error("image copy did not end after the last row");

    a_load_value: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (state_reg == bram_pkg::ST_LOAD && !shadow_valid_reg) |=> (mem_reg[$past(ptr_reg)] == INIT_WORD))
        else $error("loaded row differs from the initial image");

    a_ports_stalled: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        busy_out |-> (en == 2'b00))
        else $error("port served while the image copy ran");

    a_mode_roles: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (MODE != bram_pkg::MODE_TRUE_DP) |-> !we[1])
        else $error("port b wrote outside true dual port mode");

    a_wide_refused: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (MODE == bram_pkg::MODE_TRUE_DP && (A_WIDTH == 36 || B_WIDTH == 36)) |-> (config_err_out && en == 2'b00))
        else $error("36 bit shape accepted with two read/write ports");

    a_row_map: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        en[0] |-> (32'(row[0]) == (32'(a_addr_in) * A_WIDTH) / bram_pkg::ROW_W))
        else $error("port a word landed in the wrong row");

    a_write_lands: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (we[0] && !(we[1] && row[0] == row[1]))
        |=> ((mem_reg[$past(row[0])] & $past(mask[0])) == ($past(bits[0]) & $past(mask[0]))))
        else $error("port a write did not land in its bits");
endmodule

// >>> fabric_port_model.sv
// Purpose: user fabric logic that drives one memory port and collects its read data
// Assumes: requests change at the falling edge; LAT is the port's read latency in rising clock edges
// Notes: released address and data lines show the inverse of their last value
module fabric_port_model #(
    parameter int LAT = 1
) (
    input wire logic ref_clk_in,
    output logic clk_en_out,
    output logic rst_out,
    output logic write_en_out,
    output logic [13:0] addr_out,
    output logic [35:0] wdata_out,
    output logic [3:0] byte_en_out,
    input wire logic [35:0] rdata_in,
    input wire logic parity_err_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        clk_en_out = 1'b0;
        rst_out = 1'b0;
        write_en_out = 1'b0;
        addr_out = 14'h0000;
        wdata_out = 36'h000000000;
        byte_en_out = 4'h0;
    end

    // the fabric sequences every access itself; the memory holds no queue control
    task automatic drive(input logic we, input logic [13:0] a, input logic [35:0] d, input logic [3:0] be);
        @(negedge ref_clk_in);
        clk_en_out = 1'b1;
        write_en_out = we;
        addr_out = a;
        wdata_out = d;
        byte_en_out = be;
    endtask

    task automatic release_port();
        clk_en_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
        byte_en_out = ~byte_en_out;
    endtask

    // port reset for one cycle: clears this port's read registers, never the array
    task automatic port_reset();
        @(negedge ref_clk_in);
        rst_out = 1'b1;
        @(negedge ref_clk_in);
        rst_out = 1'b0;
    endtask

    task automatic write_word(input logic [13:0] a, input logic [35:0] d, input logic [3:0] be);
        drive(1'b1, a, d, be);
        @(negedge ref_clk_in);
        release_port();
    endtask

    // clock enable stays high until the read data has crossed every read register
    task automatic read_word(input logic [13:0] a, output logic [35:0] d, output logic p);
        drive(1'b0, a, 36'h000000000, 4'h0);
        repeat (LAT) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        d = rdata_in;
        p = parity_err_in;
        release_port();
    endtask
endmodule

// >>> configurable_block_ram_tb.sv
// Purpose: self-checking bench of the block ram in true dual port mode, 18 bits on a and 9 on b
// Assumes: parity generation on, port b with output register, preset image with one odd lane
// Notes: a second instance with a 36-bit port in true dual mode must flag a configuration error
module configurable_block_ram_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [35:0] INIT = 36'h8180c0603;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic load_image_in = 1'b0;
    logic save_image_in = 1'b0;
    logic a_ce, a_rst, a_we, b_ce, b_rst, b_we, a_perr, b_perr, busy, cfg_err, wide_err, wide_busy;
    logic [13:0] a_addr, b_addr;
    logic [35:0] a_wd, b_wd, a_rd, b_rd, d, wide_rd;
    logic [3:0] a_be, b_be;
    logic p;
    int n;
    int errors = 0;
    int num_checks = 0;

    always #2.5 ref_clk_in = ~ref_clk_in;

    configurable_block_ram #(.MODE(bram_pkg::MODE_TRUE_DP), .A_WIDTH(18), .B_WIDTH(9), .A_OUT_REG(1'b0),
        .B_OUT_REG(1'b1), .PARITY_GEN(1'b1), .INIT_WORD(INIT)) u_configurable_block_ram (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .a_clk_en_in(a_ce), .a_rst_in(a_rst),
        .a_write_en_in(a_we), .a_addr_in(a_addr), .a_wdata_in(a_wd), .a_byte_en_in(a_be),
        .a_rdata_out(a_rd), .a_parity_err_out(a_perr), .b_clk_en_in(b_ce), .b_rst_in(b_rst),
        .b_write_en_in(b_we), .b_addr_in(b_addr), .b_wdata_in(b_wd), .b_byte_en_in(b_be),
        .b_rdata_out(b_rd), .b_parity_err_out(b_perr), .load_image_in(load_image_in),
        .save_image_in(save_image_in), .busy_out(busy), .config_err_out(cfg_err));

    configurable_block_ram #(.MODE(bram_pkg::MODE_TRUE_DP), .A_WIDTH(36)) u_configurable_block_ram_wide (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .a_clk_en_in(a_ce), .a_rst_in(a_rst),
        .a_write_en_in(a_we), .a_addr_in(a_addr), .a_wdata_in(a_wd), .a_byte_en_in(a_be),
        .a_rdata_out(wide_rd), .a_parity_err_out(), .b_clk_en_in(b_ce), .b_rst_in(b_rst),
        .b_write_en_in(b_we), .b_addr_in(b_addr), .b_wdata_in(b_wd), .b_byte_en_in(b_be),
        .b_rdata_out(), .b_parity_err_out(), .load_image_in(load_image_in),
        .save_image_in(save_image_in), .busy_out(wide_busy), .config_err_out(wide_err));

    fabric_port_model #(.LAT(1)) u_fabric_port_model_a (.ref_clk_in(ref_clk_in), .clk_en_out(a_ce),
        .rst_out(a_rst), .write_en_out(a_we), .addr_out(a_addr), .wdata_out(a_wd), .byte_en_out(a_be),
        .rdata_in(a_rd), .parity_err_in(a_perr));
    fabric_port_model #(.LAT(2)) u_fabric_port_model_b (.ref_clk_in(ref_clk_in), .clk_en_out(b_ce),
        .rst_out(b_rst), .write_en_out(b_we), .addr_out(b_addr), .wdata_out(b_wd), .byte_en_out(b_be),
        .rdata_in(b_rd), .parity_err_in(b_perr));

    // stored form of one lane: top bit is the even parity of the byte
    function automatic logic [8:0] lane(input logic [8:0] x);
        return {^x[7:0], x[7:0]};
    endfunction

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_idle(output int cnt);
        cnt = 0;
        while (busy === 1'b1 && cnt < 1000) begin
            @(negedge ref_clk_in);
            cnt++;
        end
    endtask

    task automatic image_op(input bit load, input bit wait_done, output int cnt);
        @(negedge ref_clk_in);
        load_image_in = load;
        save_image_in = !load;
        @(negedge ref_clk_in);
        load_image_in = 1'b0;
        save_image_in = 1'b0;
        cnt = 0;
        if (wait_done) begin
            wait_idle(cnt);
        end
    endtask

    task automatic test_init_image();
        u_fabric_port_model_a.read_word(14'd4, d, p);
        check("init word 4", d, 36'h000000603);
        check("init word 4 parity", {35'h0, p}, 36'h0);
        check("wide shape port idle", wide_rd, 36'h0);
        u_fabric_port_model_a.read_word(14'd5, d, p);
        check("init word 5", d, 36'h000020603);
        check("init word 5 parity", {35'h0, p}, 36'h1);
        u_fabric_port_model_b.read_word(14'd11, d, p);
        check("init lane via b", d, 36'h000000103);
        check("init lane b parity", {35'h0, p}, 36'h1);
        $display("test_init_image done");
    endtask

    task automatic test_width_map();
        logic [17:0] w;
        w = 18'h2d1a5;
        u_fabric_port_model_a.write_word(14'd10, {18'h0, w}, 4'h3);
        u_fabric_port_model_b.read_word(14'd20, d, p);
        check("b word 20", d, {27'h0, lane(w[8:0])});
        u_fabric_port_model_b.read_word(14'd21, d, p);
        check("b word 21", d, {27'h0, lane(w[17:9])});
        u_fabric_port_model_a.read_word(14'd10, d, p);
        check("a word 10", d, {18'h0, lane(w[17:9]), lane(w[8:0])});
        check("a word 10 parity", {35'h0, p}, 36'h0);
        u_fabric_port_model_a.write_word(14'd10, 36'h00003ffff, 4'h1);
        u_fabric_port_model_a.read_word(14'd10, d, p);
        check("byte enable lane 0", d, {18'h0, lane(w[17:9]), lane(9'h1ff)});
        $display("test_width_map done");
    endtask

    task automatic test_both_ports();
        fork
            u_fabric_port_model_a.write_word(14'd30, 36'h000000000, 4'h3);
            u_fabric_port_model_b.write_word(14'd60, 36'h0000000ff, 4'hf);
        join
        u_fabric_port_model_a.read_word(14'd30, d, p);
        check("same row writes", d, {18'h0, lane(9'h000), lane(9'h0ff)});
        u_fabric_port_model_a.write_word(14'd1024, 36'h000000000, 4'h3);
        u_fabric_port_model_a.read_word(14'd0, d, p);
        check("out of range write", d, 36'h000000603);
        check("36 bit true dual refused", {35'h0, wide_err}, 36'h1);
        check("legal shape accepted", {35'h0, cfg_err}, 36'h0);
        $display("test_both_ports done");
    endtask

    task automatic test_image();
        u_fabric_port_model_a.write_word(14'd0, 36'h000000abc, 4'h3);
        image_op(1'b0, 1'b1, n);
        check("save busy cycles", n, 512);
        u_fabric_port_model_a.write_word(14'd0, 36'h000000000, 4'h3);
        image_op(1'b1, 1'b0, n);
        u_fabric_port_model_a.write_word(14'd0, 36'h000000000, 4'h3);
        wait_idle(n);
        u_fabric_port_model_a.read_word(14'd0, d, p);
        check("reload from saved image", d, {18'h0, lane(9'h005), lane(9'h0bc)});
        image_op(1'b1, 1'b1, n);
        check("load busy cycles", n, 512);
        $display("test_image done");
    endtask

    task automatic test_reset();
        u_fabric_port_model_b.read_word(14'd11, d, p);
        check("b word 11 before port reset", d, 36'h000000103);
        fork
            u_fabric_port_model_a.port_reset();
            u_fabric_port_model_b.port_reset();
        join
        check("a data after port reset", a_rd, 36'h0);
        check("b data after port reset", b_rd, 36'h0);
        check("b parity after port reset", {35'h0, b_perr}, 36'h0);
        @(negedge ref_clk_in);
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        check("busy in reset load", {35'h0, busy}, 36'h1);
        wait_idle(n);
        check("reset load cycles", n, 512);
        u_fabric_port_model_a.read_word(14'd0, d, p);
        check("reset empties saved image", d, 36'h000000603);
        $display("test_reset done");
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(negedge ref_clk_in);
        rst_in = 1'b0;
        @(negedge ref_clk_in);
        wait_idle(n);
        check("busy after reset", {35'h0, busy}, 36'h0);
        check("wide busy after reset", {35'h0, wide_busy}, 36'h0);
        test_init_image();
        test_width_map();
        test_both_ports();
        test_image();
        test_reset();
        print_verdict();
    end
endmodule
